/* include/sac_pkg.sv */
// constants, register map and field layout of the sar converter control block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package sac_pkg;
  // ------------------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------------------
  localparam logic [7:0] SAC_ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] SAC_ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] SAC_ADDR_RESH = 8'h08;
  localparam logic [7:0] SAC_ADDR_RESL = 8'h0c;
  localparam logic [7:0] SAC_ADDR_IRQ = 8'h10;
  // ------------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------------
  localparam int SAC_C0_EN = 0;
  localparam int SAC_C0_GO = 1;
  localparam int SAC_C0_CHS_LO = 2;
  localparam int SAC_C1_PREF_LO = 0;
  localparam int SAC_C1_NREF = 2;
  localparam int SAC_C1_CS_LO = 4;
  localparam int SAC_C1_FMT = 7;
  localparam int SAC_IRQ_FLAG = 0;
  localparam int SAC_IRQ_IE = 1;
  localparam int SAC_IRQ_PE = 2;
  localparam int SAC_IRQ_GE = 3;
  // ------------------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------------------
  localparam logic [7:0] SAC_RST_BYTE = 8'h00;
  localparam int SAC_RES_BITS = 10;
  localparam logic [4:0] SAC_SETUP_HALF = 5'h04; // first decision half tick
  localparam logic [4:0] SAC_LAST_HALF = 5'h16; // 23rd half tick = 11.5 periods
  localparam logic [3:0] SAC_MSB_IDX = 4'h9;
  localparam logic [1:0] SAC_CS_RC = 2'h3; // low bits of conv_clock_select
  typedef enum logic [1:0] {SAC_IDLE, SAC_CONV} sac_state_type;
endpackage

/* verilog/sac_control.sv */
// sar converter control: wishbone registers, bit clock, conversion sequencer
`timescale 1ns/100ps
module sac_control (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cpu sleep and wake
  input wire logic sleep_i,
  output logic wake_o,
  output logic vector_o,
  // analog array
  input wire logic comp_i,
  input wire logic rc_clk_i,
  output logic [5:0] channel_select_o,
  output logic [1:0] positive_ref_select_o,
  output logic neg_ref_pin_o,
  output logic hold_o,
  output logic [9:0] trial_o
);
  import sac_pkg::*;

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] resh_reg;
  logic [7:0] resl_reg;
  logic flag_reg, ie_reg, pe_reg, ge_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  sac_state_type state_reg;
  logic [4:0] phase_reg;
  logic [3:0] bit_reg;
  logic [9:0] sar_reg;
  logic last_reg, any_dec_reg;
  logic [5:0] presc_reg;
  logic comp_s1, comp_s2, rc_s1, rc_s2, rc_s3;
  logic wake_reg, vector_reg;

  // decoded bus strobes; writes land the cycle ack is raised
  logic wr_en, wr_c0, wr_c1, wr_rh, wr_rl, wr_irq;
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg & wb_sel_i[0];
  assign wr_c0 = wr_en & (wb_adr_i == SAC_ADDR_CTRL0);
  assign wr_c1 = wr_en & (wb_adr_i == SAC_ADDR_CTRL1);
  assign wr_rh = wr_en & (wb_adr_i == SAC_ADDR_RESH);
  assign wr_rl = wr_en & (wb_adr_i == SAC_ADDR_RESL);
  assign wr_irq = wr_en & (wb_adr_i == SAC_ADDR_IRQ);

  // --------------------------------------------------------------------------
  // synchronisers for the asynchronous comparator and rc oscillator
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      rc_s3 <= 1'b0;
    end else begin
      comp_s1 <= comp_i;
      comp_s2 <= comp_s1;
      rc_s1 <= rc_clk_i;
      rc_s2 <= rc_s1;
      rc_s3 <= rc_s2;
    end
  end

  // --------------------------------------------------------------------------
  // bit clock: half-period ticks
  // --------------------------------------------------------------------------
  logic rc_sel, half_tick, busy, done, abort_sw, abort_sleep;
  logic [5:0] half_len;
  assign rc_sel = (ctrl1_reg[SAC_C1_CS_LO +: 2] == SAC_CS_RC);
  assign busy = (state_reg == SAC_CONV);
  // divide ratio decode: half period = div/2 system clocks
  always_comb begin
    unique case (ctrl1_reg[SAC_C1_CS_LO +: 2])
      2'h0: half_len = 6'h01;
      2'h1: half_len = 6'h04;
      2'h2: half_len = 6'h10;
      default: half_len = 6'h01;
    endcase
    if (ctrl1_reg[SAC_C1_CS_LO + 2]) begin
      half_len = {half_len[4:0], 1'b0};
    end
  end
  // prescaler runs from the system clock, so it scales with it
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      presc_reg <= 6'h00;
    end else if (!busy || presc_reg == half_len - 6'h01) begin
      presc_reg <= 6'h00;
    end else begin
      presc_reg <= presc_reg + 6'h01;
    end
  end
  // every rc edge is one half period; otherwise the prescaler wrap
  assign half_tick = rc_sel ? (rc_s2 ^ rc_s3) : (busy && presc_reg == half_len - 6'h01);

  // --------------------------------------------------------------------------
  // conversion sequencer
  // --------------------------------------------------------------------------
  // without the rc clock, sleep kills the conversion with no result
  assign abort_sleep = busy & sleep_i & ~rc_sel;
  assign abort_sw = busy & wr_c0 & ~wb_dat_i[SAC_C0_GO];
  // last decision falls on the 23rd half tick
  assign done = busy & half_tick & (phase_reg == SAC_LAST_HALF) & ~abort_sleep & ~abort_sw;

  logic start;
  // start needs enable already on; the same write cannot turn both on
  assign start = ~busy & wr_c0 & wb_dat_i[SAC_C0_GO] & ctrl0_reg[SAC_C0_EN]
                 & wb_dat_i[SAC_C0_EN] & ~(sleep_i & ~rc_sel);

  logic decide;
  assign decide = half_tick & (phase_reg >= SAC_SETUP_HALF) & ~phase_reg[0];

  // successive approximation, one bit per bit period
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg <= SAC_IDLE;
      phase_reg <= 5'h00;
      bit_reg <= SAC_MSB_IDX;
      sar_reg <= 10'h000;
      last_reg <= 1'b0;
      any_dec_reg <= 1'b0;
    end else if (start) begin
      state_reg <= SAC_CONV;
      phase_reg <= 5'h00;
      bit_reg <= SAC_MSB_IDX;
      sar_reg <= 10'h200;
      any_dec_reg <= 1'b0;
    end else if (done || abort_sleep || abort_sw || !ctrl0_reg[SAC_C0_EN]) begin
      state_reg <= SAC_IDLE;
    end else if (busy && half_tick) begin
      phase_reg <= phase_reg + 5'h01;
      if (decide) begin
        sar_reg[bit_reg] <= comp_s2;
        if (bit_reg != 4'h0) begin
          sar_reg[bit_reg - 4'h1] <= 1'b1;
          bit_reg <= bit_reg - 4'h1;
        end
        last_reg <= comp_s2;
        any_dec_reg <= 1'b1;
      end
    end
  end

  // partial result: unconverted bits copy the last decided bit
  logic [9:0] part_res, final_res;
  genvar gi;
  generate
    for (gi = 0; gi < SAC_RES_BITS; gi++) begin : g_fill
      assign part_res[gi] = (4'(gi) > bit_reg) ? sar_reg[gi] : (last_reg & any_dec_reg);
    end
  endgenerate
  // completion result includes the final comparator decision on bit 0
  assign final_res = {sar_reg[9:1], comp_s2};

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl0_reg <= SAC_RST_BYTE;
      ctrl1_reg <= SAC_RST_BYTE;
    end else begin
      // channel in bits 7..2, start/done at bit 1, enable at bit 0
      if (wr_c0) begin
        ctrl0_reg <= wb_dat_i[7:0];
        ctrl0_reg[SAC_C0_GO] <= start | (busy & wb_dat_i[SAC_C0_GO]);
      end
      // start/done drops by hardware at end or abort
      if (done || abort_sleep || (busy && !ctrl0_reg[SAC_C0_EN])) begin
        ctrl0_reg[SAC_C0_GO] <= 1'b0;
      end
      if (wr_c1) begin
        ctrl1_reg <= wb_dat_i[7:0];
      end
    end
  end

  // result formatted when stored; software may also write the bytes
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      resh_reg <= SAC_RST_BYTE;
      resl_reg <= SAC_RST_BYTE;
    end else if (done || abort_sw) begin
      if (ctrl1_reg[SAC_C1_FMT]) begin
        resh_reg <= {6'h00, (done ? final_res[9:8] : part_res[9:8])};
        resl_reg <= done ? final_res[7:0] : part_res[7:0];
      end else begin
        resh_reg <= done ? final_res[9:2] : part_res[9:2];
        resl_reg <= {(done ? final_res[1:0] : part_res[1:0]), 6'h00};
      end
    end else begin
      if (wr_rh) begin
        resh_reg <= wb_dat_i[7:0];
      end
      if (wr_rl) begin
        resl_reg <= wb_dat_i[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // completion flag and interrupt enables
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      flag_reg <= 1'b0;
      ie_reg <= 1'b0;
      pe_reg <= 1'b0;
      ge_reg <= 1'b0;
    end else begin
      if (wr_irq) begin
        flag_reg <= wb_dat_i[SAC_IRQ_FLAG];
        ie_reg <= wb_dat_i[SAC_IRQ_IE];
        pe_reg <= wb_dat_i[SAC_IRQ_PE];
        ge_reg <= wb_dat_i[SAC_IRQ_GE];
      end
      // set on every completion; set beats a same-cycle clear
      if (done) begin
        flag_reg <= 1'b1;
      end
    end
  end

  // wake on flagged completion while asleep; vector needs all enables
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wake_reg <= 1'b0;
      vector_reg <= 1'b0;
    end else begin
      wake_reg <= sleep_i & flag_reg & ie_reg;
      vector_reg <= flag_reg & ie_reg & pe_reg & ge_reg;
    end
  end

  // --------------------------------------------------------------------------
  // wishbone answer: one wait state, unmapped reads give zero
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
      unique case (wb_adr_i)
        SAC_ADDR_CTRL0: rdat_reg <= {24'h000000, ctrl0_reg};
        SAC_ADDR_CTRL1: rdat_reg <= {24'h000000, ctrl1_reg};
        SAC_ADDR_RESH: rdat_reg <= {24'h000000, resh_reg};
        SAC_ADDR_RESL: rdat_reg <= {24'h000000, resl_reg};
        SAC_ADDR_IRQ: rdat_reg <= {28'h0000000, ge_reg, pe_reg, ie_reg, flag_reg};
        default: rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // outputs, all straight from flip-flops except hold_o, decoded from state_reg
  // --------------------------------------------------------------------------
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign wake_o = wake_reg;
  assign vector_o = vector_reg;
  assign channel_select_o = ctrl0_reg[SAC_C0_CHS_LO +: 6];
  // positive reference code passed to the reference mux
  assign positive_ref_select_o = ctrl1_reg[SAC_C1_PREF_LO +: 2];
  // negative reference: 1 selects the pin, 0 ground
  assign neg_ref_pin_o = ctrl1_reg[SAC_C1_NREF];
  assign hold_o = (state_reg == SAC_CONV);
  assign trial_o = sar_reg;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  logic [4:0] chk_ticks;
  always_ff @(posedge clk_i) begin
    if (!resetn_i || start) begin
      chk_ticks <= 5'h00;
    end else if (busy && half_tick && chk_ticks != 5'h1f) begin
      chk_ticks <= chk_ticks + 5'h01;
    end
  end

  a_start_needs_enable: assert property ($rose(hold_o) |-> $past(ctrl0_reg[SAC_C0_EN]))
    else $error("conversion began with converter disabled");
  a_conv_length: assert property (done |-> chk_ticks == 5'h16)
    else $error("conversion did not take 23 half periods");
  a_done_flag_go: assert property (done |=> flag_reg && !ctrl0_reg[SAC_C0_GO])
    else $error("completion did not set flag and clear start");
  a_flag_sticky: assert property (flag_reg && !wr_irq |=> flag_reg)
    else $error("flag cleared without software");
  a_sleep_abort: assert property (abort_sleep |=> !hold_o ##0 !ctrl0_reg[SAC_C0_GO])
    else $error("sleep did not stop non-rc conversion");
  a_right_just: assert property (done && ctrl1_reg[SAC_C1_FMT] |=> resh_reg[7:2] == 6'h00)
    else $error("right justified high byte has set upper bits");
  a_vector_cond: assert property (vector_o |-> $past(ie_reg && pe_reg && ge_reg))
    else $error("vector raised without all enables");
  a_wake_sleep: assert property (wake_o |-> $past(sleep_i) && $past(ie_reg))
    else $error("wake raised outside enabled sleep");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_channel_map: assert property (wr_c0 |=> channel_select_o == $past(wb_dat_i[7:2]))
    else $error("channel output does not follow field");
endmodule

/* verification/sac_analog_model.sv */
// behavioural model of the analog multiplexer, comparator array and rc oscillator
`timescale 1ns/100ps
module sac_analog_model (
  // converter side
  input wire logic hold_i,
  input wire logic [5:0] channel_i,
  input wire logic [9:0] trial_i,
  // answers
  output logic comp_o,
  output logic rc_clk_o
);
  // ----------------------------------------------------------------------
  // input level per channel
  // ----------------------------------------------------------------------
  logic [9:0] level;
  assign level = {channel_i, channel_i[3:0]} ^ 10'h155;
  // comparator for the trial code
  // input sits half a step above level, so above and at-or-above agree
  assign comp_o = (level >= trial_i);
  // ----------------------------------------------------------------------
  // rc oscillator
  // ----------------------------------------------------------------------
  // runs only while converting; period unrelated to the system clock
  initial begin
    rc_clk_o = 1'b0;
    forever begin
      #230;
      if (hold_i === 1'b1) begin
        rc_clk_o = ~rc_clk_o;
      end
    end
  end
endmodule

/* verification/tb.sv */
// register-level testbench of the sar converter control block
`timescale 1ns/100ps
module tb;
  import sac_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic clk_i, resetn_i, cyc, stb, we, sleep, comp, rc_clk, ack, wake, vector, nref, hold;
  logic [7:0] adr, q;
  logic [3:0] sel, lane;
  logic [31:0] dat_w, dat_r;
  logic [5:0] chs;
  logic [1:0] pref;
  logic [9:0] trial;
  int mismatches, checks;

  sac_control dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .sleep_i(sleep), .wake_o(wake), .vector_o(vector), .comp_i(comp),
    .rc_clk_i(rc_clk), .channel_select_o(chs), .positive_ref_select_o(pref),
    .neg_ref_pin_o(nref), .hold_o(hold), .trial_o(trial));
  sac_analog_model model_u (.hold_i(hold), .channel_i(chs), .trial_i(trial),
    .comp_o(comp), .rc_clk_o(rc_clk));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one classic wishbone cycle; the request stands until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lane;
    adr <= a;
    dat_w <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    // a missing answer is a failure, not a silent retry
    if (ack !== 1'b1) begin
      mismatches++;
      $display("MISMATCH ack expected 1 seen %b", ack);
    end
    r = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask

  // set up, wait acquisition, convert, time it on a divider clock and read the result back unless dividing by 2 or 4
  task convert(input logic [2:0] cs, input logic fmt, input logic [5:0] ch, input int div);
    logic [9:0] v;
    int n;
    int t;
    v = {ch, ch[3:0]} ^ 10'h155;
    t = 23 * div / 2;
    wb(1'b1, SAC_ADDR_CTRL1, {fmt, cs, 1'b0, ch[0], ch[2:1]}, q);
    wb(1'b0, SAC_ADDR_CTRL1, 8'h00, q);
    chk("ctrl1", {2'b00, fmt, cs, 1'b0, ch[0], ch[2:1]}, {2'b00, q});
    wb(1'b1, SAC_ADDR_CTRL0, {ch, 2'b01}, q);
    repeat (50) @(posedge clk_i);
    chk("channel", {4'h0, ch}, {4'h0, chs});
    chk("pos_ref", {8'h00, ch[2:1]}, {8'h00, pref});
    chk("neg_ref", {9'h000, ch[0]}, {9'h000, nref});
    wb(1'b1, SAC_ADDR_CTRL0, {ch, 2'b11}, q);
    n = 0;
    while (hold === 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    // a conversion that never ends counts even where timing is not judged
    if (n >= 3000) begin
      mismatches++;
      $display("MISMATCH hold expected 0 seen %b", hold);
    end
    // tolerance covers synchroniser and bus latency
    if (div > 0) begin
      chk("cycles", 10'(t), (n >= t - 3 && n <= t + 3) ? 10'(t) : 10'(n));
    end
    wb(1'b0, SAC_ADDR_CTRL0, 8'h00, q);
    chk("go_done", {2'b00, ch, 2'b01}, {2'b00, q});
    // divide by 2 breaks the bit period; the result bytes are not read at divide by 2 or 4
    if (div == 0 || div >= 8) begin
      wb(1'b0, SAC_ADDR_RESH, 8'h00, q);
      chk("res_high", fmt ? {8'h00, v[9:8]} : {2'b00, v[9:2]}, {2'b00, q});
      wb(1'b0, SAC_ADDR_RESL, 8'h00, q);
      chk("res_low", fmt ? {2'b00, v[7:0]} : {2'b00, v[1:0], 6'h00}, {2'b00, q});
    end
    wb(1'b0, SAC_ADDR_IRQ, 8'h00, q);
    chk("flag_set", 10'h001, {9'h000, q[0]});
  endtask

  // ----------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  // 50 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // cut a hang short well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    end_sim;
  end

  initial begin
    {resetn_i, cyc, stb, we, sleep} = 5'h00;
    adr = 8'h00;
    dat_w = 32'h00000000;
    sel = 4'h0;
    lane = 4'h1;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    wb(1'b1, 8'h14, 8'hff, q);
    // reset values, unmapped place included
    for (int a = 0; a < 6; a++) begin
      wb(1'b0, 8'(a * 4), 8'h00, q);
      chk("reset", 10'h000, {2'b00, q});
    end
    // start in the same write that turns the converter on is ignored
    wb(1'b1, SAC_ADDR_CTRL0, 8'h03, q);
    wb(1'b0, SAC_ADDR_CTRL0, 8'h00, q);
    chk("go_refused", 10'h001, {2'b00, q});
    // a write without the low byte lane selected leaves the register alone
    lane = 4'h0;
    wb(1'b1, SAC_ADDR_CTRL1, 8'hff, q);
    lane = 4'h1;
    wb(1'b0, SAC_ADDR_CTRL1, 8'h00, q);
    chk("sel_refused", 10'h000, {2'b00, q});
    // every divider code, both formats
    for (int i = 0; i < 6; i++) begin
      convert({i[0], i[2:1]}, i[0], 6'(i * 9 + 3), 2 << i);
      repeat (20) @(posedge clk_i);
      wb(1'b0, SAC_ADDR_IRQ, 8'h00, q);
      chk("flag_kept", 10'h001, {9'h000, q[0]});
      wb(1'b1, SAC_ADDR_IRQ, 8'h00, q);
    end
    // rc clock keeps converting in sleep and wakes the cpu
    wb(1'b1, SAC_ADDR_IRQ, 8'h02, q);
    fork
      convert(3'b111, 1'b0, 6'h11, 0);
      begin
        wait (hold === 1'b1);
        @(posedge clk_i);
        sleep <= 1'b1;
      end
    join
    chk("wake", 10'h001, {9'h000, wake});
    chk("no_vector", 10'h000, {9'h000, vector});
    wb(1'b1, SAC_ADDR_IRQ, 8'h0f, q);
    repeat (2) @(posedge clk_i);
    chk("vector", 10'h001, {9'h000, vector});
    wb(1'b1, SAC_ADDR_IRQ, 8'h00, q);
    sleep <= 1'b0;
    // sleep with a divider clock aborts without a flag
    wb(1'b1, SAC_ADDR_CTRL1, 8'h50, q);
    wb(1'b1, SAC_ADDR_CTRL0, 8'hab, q);
    sleep <= 1'b1;
    repeat (300) @(posedge clk_i);
    chk("sleep_hold", 10'h000, {9'h000, hold});
    wb(1'b0, SAC_ADDR_IRQ, 8'h00, q);
    chk("sleep_flag", 10'h000, {9'h000, q[0]});
    sleep <= 1'b0;
    // software abort mid-conversion fills undecided bits
    wb(1'b1, SAC_ADDR_CTRL1, 8'he0, q);
    wb(1'b1, SAC_ADDR_CTRL0, 8'hab, q);
    repeat (400) @(posedge clk_i);
    wb(1'b1, SAC_ADDR_CTRL0, 8'ha9, q);
    repeat (5) @(posedge clk_i);
    wb(1'b0, SAC_ADDR_RESH, 8'h00, q);
    chk("part_high", 10'h003, {2'b00, q});
    wb(1'b0, SAC_ADDR_RESL, 8'h00, q);
    chk("part_low", 10'h0ff, {2'b00, q});
    end_sim;
  end
endmodule
